/* e1_diag_pkg.sv */
// Constants for the eight-channel E1 diagnostic control block
//
// What this block does
// - Remote loopback sends the recovered clock and data out on the line outputs.
// - During remote loopback the transmit clock and data inputs are disregarded.
// - Remote loopback suppresses all-ones transmission even when it is requested.
// - Hardware mode: transmit clock high over 16 reference cycles starts all-ones.
// - Host mode: all-ones select bit forces all-ones on that channel.
// - Host mode: automatic select inserts all-ones while the channel reports signal loss.
// - All-ones bit timing comes from the reference clock, not the transmit clock.
// - Digital loopback is blocked while all-ones is active on that channel.
// - Eight normal channels, or channel 0 dedicated to monitoring another channel.
// - Monitor picks receiver or transmitter of channel 1 to 7, pins or register.
// - Monitored line signal appears on channel 0 recovered clock and data outputs.
// - Channel 0 reports signal loss of the monitored signal, either direction.
// - Monitoring via remote loopback: channel 0 transmits the monitored channel's data.
// - Transmit line outputs can be tristated at once per channel.
// - Jitter attenuator path has a fixed throughput delay.
// - Mode pin low selects hardware mode and disables the host interface.
// - In hardware mode separate hw pins give static configuration inputs and status outputs.
// - Analog loopback feeds transmit line outputs back to the receiver, ignoring line input.
// - Digital loopback, host mode only, returns transmit clock and data to receive outputs.
// - Attenuator delay is 16 bits shallow, 32 bits deep.
package e1_diag_pkg;
    localparam logic [3:0] ADDR_RLOOP      = 4'h0;
    localparam logic [3:0] ADDR_ALOOP      = 4'h1;
    localparam logic [3:0] ADDR_DIGITAL_LOOPBACK_SELECT      = 4'h2;
    localparam logic [3:0] ADDR_ALLONES    = 4'h3;
    localparam logic [3:0] ADDR_AUTOONES   = 4'h4;
    localparam logic [3:0] ADDR_OUTEN      = 4'h5;
    localparam logic [3:0] ADDR_MON        = 4'h6;
    localparam logic [3:0] ADDR_JA         = 4'h7;
    localparam logic [3:0] ADDR_LOSS_ST    = 4'h8;
    localparam logic [3:0] ADDR_ONES_ST    = 4'h9;
    localparam int         MON_EN_BIT      = 0;
    localparam int         MON_DIR_BIT     = 1;
    localparam int         MON_SEL_LSB     = 2;
    localparam int         JA_TX_BIT       = 0;
    localparam int         JA_DEEP_BIT     = 1;
    localparam logic [7:0] RST_CTRL        = 8'h00;
    localparam logic [4:0] RST_MON         = 5'h00;
    localparam logic [1:0] RST_JA          = 2'h0;
    localparam logic [4:0] ONES_HIGH_LIMIT = 5'd16;
    localparam int         JA_SHORT_BITS   = 16;
    localparam int         JA_DEEP_BITS    = 32;
endpackage

/* e1_diag_ctrl.sv */
// Loopback, all-ones, monitoring and output-enable control for eight E1 channels
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module e1_diag_ctrl
    import e1_diag_pkg::*;
#(
    parameter int CHN = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [3:0]       regAddr,
    input  wire logic [7:0]       regWrData,
    input  wire logic             regWrEn,
    input  wire logic             regRdEn,
    output logic      [7:0]       regRdData,
    input  wire logic             modeSel,
    input  wire logic             mclkIn,
    input  wire logic [CHN-1:0]   transmitClockIn,
    input  wire logic [CHN-1:0]   transmitPosData,
    input  wire logic [CHN-1:0]   transmitNegData,
    input  wire logic [CHN-1:0]   cdrClkIn,
    input  wire logic [CHN-1:0]   cdrPosIn,
    input  wire logic [CHN-1:0]   cdrNegIn,
    input  wire logic [CHN-1:0]   rxSignalLossIn,
    input  wire logic [CHN-1:0]   txSignalLossIn,
    input  wire logic [CHN-1:0]   hwOutEnPin,
    input  wire logic [CHN-1:0]   hwRemoteLoopPin,
    input  wire logic [CHN-1:0]   hwAnalogLoopPin,
    input  wire logic             hwMonEnPin,
    input  wire logic             hwMonDirPin,
    input  wire logic [2:0]       hwMonSelPin,
    input  wire logic             hwJaTxPin,
    output logic      [CHN-1:0]   lineOutPlus,
    output logic      [CHN-1:0]   lineOutMinus,
    output logic      [CHN-1:0]   lineOutEn,
    output logic      [CHN-1:0]   recoveredClk,
    output logic      [CHN-1:0]   recoveredPosData,
    output logic      [CHN-1:0]   recoveredNegData,
    output logic      [CHN-1:0]   signalLossOut,
    output logic      [CHN-1:0]   hwStatusOut
);
    localparam int SW = 2 + 9 * CHN + 2 * CHN + 6;

    // Every pin except the register interface passes two flops; first stage feeds only the second
    logic [SW-1:0]  syncMeta_reg;
    logic [SW-1:0]  syncQ_reg;
    logic           modeS;
    logic           mclkS;
    logic [CHN-1:0] tclkS, tposS, tnegS, rclkS, rposS, rnegS, losS, txLosS, oeS;
    logic [CHN-1:0] hwRl, hwAl;
    logic           hwMe, hwMd, hwJt;
    logic [2:0]     hwMs;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncMeta_reg <= '0;
            syncQ_reg    <= '0;
        end else begin
            syncMeta_reg <= {modeSel, mclkIn, transmitClockIn, transmitPosData, transmitNegData,
                             cdrClkIn, cdrPosIn, cdrNegIn, rxSignalLossIn, txSignalLossIn,
                             hwOutEnPin, hwRemoteLoopPin, hwAnalogLoopPin, hwMonEnPin,
                             hwMonDirPin, hwMonSelPin, hwJaTxPin};
            syncQ_reg    <= syncMeta_reg;
        end
    end

    assign {modeS, mclkS, tclkS, tposS, tnegS, rclkS, rposS, rnegS, losS, txLosS, oeS,
            hwRl, hwAl, hwMe, hwMd, hwMs, hwJt} = syncQ_reg;

    // Host registers
    logic [CHN-1:0] rloop_reg, aloop_reg, digital_loopback_select_reg, allOnesSel_reg, autoOnes_reg, outEn_reg;
    logic [4:0]     mon_reg;
    logic [1:0]     ja_reg;
    logic           hwMode;

    assign hwMode = ~modeS;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rloop_reg      <= RST_CTRL;
            aloop_reg      <= RST_CTRL;
            digital_loopback_select_reg      <= RST_CTRL;
            allOnesSel_reg <= RST_CTRL;
            autoOnes_reg   <= RST_CTRL;
            outEn_reg      <= RST_CTRL;
            mon_reg        <= RST_MON;
            ja_reg         <= RST_JA;
        end else if (regWrEn && !hwMode) begin
            case (regAddr)
                ADDR_RLOOP:    rloop_reg      <= regWrData;
                ADDR_ALOOP:    aloop_reg      <= regWrData;
                ADDR_DIGITAL_LOOPBACK_SELECT:    digital_loopback_select_reg      <= regWrData;
                ADDR_ALLONES:  allOnesSel_reg <= regWrData;
                ADDR_AUTOONES: autoOnes_reg   <= regWrData;
                ADDR_OUTEN:    outEn_reg      <= regWrData;
                ADDR_MON:      mon_reg        <= regWrData[4:0];
                ADDR_JA:       ja_reg         <= regWrData[1:0];
                default:       ;
            endcase
        end
    end

    // Effective controls: pins in hardware mode, registers in host mode
    logic [CHN-1:0] remote, analog, allOnesReq, allOnesAct, digLoop, hwAllOnes_reg;
    logic           monEn, monDir, jaTx, jaDeep, monActive;
    logic [2:0]     monSel;

    assign remote    = hwMode ? hwRl : rloop_reg;
    assign analog    = (hwMode ? hwAl : aloop_reg) & ~remote;
    assign monEn     = hwMode ? hwMe : mon_reg[MON_EN_BIT];
    assign monDir    = hwMode ? hwMd : mon_reg[MON_DIR_BIT];
    assign monSel    = hwMode ? hwMs : mon_reg[MON_SEL_LSB +: 3];
    assign monActive = monEn && (monSel != 3'd0);
    assign jaTx      = hwMode ? hwJt : ja_reg[JA_TX_BIT];
    // Hardware mode fixes the deep buffer
    assign jaDeep    = hwMode | ja_reg[JA_DEEP_BIT];
    assign allOnesReq = hwMode ? hwAllOnes_reg
                               : (allOnesSel_reg | (autoOnes_reg & losS));
    assign allOnesAct = allOnesReq & ~remote;
    assign digLoop    = {CHN{~hwMode}} & digital_loopback_select_reg & ~allOnesAct & ~remote;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 8'h00;
        end else if (regRdEn && !hwMode) begin
            case (regAddr)
                ADDR_RLOOP:    regRdData <= rloop_reg;
                ADDR_ALOOP:    regRdData <= aloop_reg;
                ADDR_DIGITAL_LOOPBACK_SELECT:    regRdData <= digital_loopback_select_reg;
                ADDR_ALLONES:  regRdData <= allOnesSel_reg;
                ADDR_AUTOONES: regRdData <= autoOnes_reg;
                ADDR_OUTEN:    regRdData <= outEn_reg;
                ADDR_MON:      regRdData <= {3'h0, mon_reg};
                ADDR_JA:       regRdData <= {6'h00, ja_reg};
                ADDR_LOSS_ST:  regRdData <= signalLossOut;
                ADDR_ONES_ST:  regRdData <= allOnesAct;
                default:       regRdData <= 8'h00;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // All-ones generator paced by the reference clock only
    logic mclkPrev_reg, onesPhase_reg, mclkRise;
    assign mclkRise = mclkS & ~mclkPrev_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mclkPrev_reg  <= 1'b0;
            onesPhase_reg <= 1'b0;
        end else begin
            mclkPrev_reg <= mclkS;
            if (mclkRise) begin
                onesPhase_reg <= ~onesPhase_reg;
            end
        end
    end

    // Count reference edges while transmit clock is held high
    logic [4:0] hiCnt_reg [CHN];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < CHN; c++) begin
                hiCnt_reg[c] <= 5'd0;
            end
            hwAllOnes_reg <= '0;
        end else begin
            for (int c = 0; c < CHN; c++) begin
                if (!tclkS[c]) begin
                    hiCnt_reg[c]     <= 5'd0;
                    hwAllOnes_reg[c] <= 1'b0;
                end else begin
                    if (mclkRise && hiCnt_reg[c] <= ONES_HIGH_LIMIT) begin
                        hiCnt_reg[c] <= hiCnt_reg[c] + 5'd1;
                    end
                    if (hiCnt_reg[c] > ONES_HIGH_LIMIT) begin
                        hwAllOnes_reg[c] <= 1'b1;
                    end
                end
            end
        end
    end

    // Per-channel source selection
    logic [CHN-1:0] rxClkEff, rxPosEff, rxNegEff, txClkSel, txPosSel, txNegSel;
    logic [CHN-1:0] jaClk, jaPosIn, jaNegIn, jaPosOut, jaNegOut, lossSel;
    logic [CHN-1:0] rcClkSrc, rcPosSrc, rcNegSrc;
    logic           monTxClk;

    // Rebuilt from its sources so channel 0 never loops back through txClkSel
    assign monTxClk = remote[monSel] ? rclkS[monSel]
                                     : allOnesAct[monSel] ? mclkS : tclkS[monSel];

    for (genvar i = 0; i < CHN; i++) begin : g_ch
        if (i == 0) begin : g_mon
            // Channel 0 recovers the monitored line instead of its own
            assign rxClkEff[i] = !monActive ? rclkS[0] : monDir ? monTxClk
                                                                : rclkS[monSel];
            assign rxPosEff[i] = !monActive ? rposS[0] : monDir ? lineOutPlus[monSel]
                                                                : rposS[monSel];
            assign rxNegEff[i] = !monActive ? rnegS[0] : monDir ? lineOutMinus[monSel]
                                                                : rnegS[monSel];
            assign lossSel[i]  = !monActive ? losS[0] : monDir ? txLosS[monSel]
                                                              : losS[monSel];
        end else begin : g_plain
            assign rxClkEff[i] = rclkS[i];
            assign rxPosEff[i] = rposS[i];
            assign rxNegEff[i] = rnegS[i];
            assign lossSel[i]  = losS[i];
        end
        // Remote loopback on channel 0 while monitoring repeats the monitored data
        assign txClkSel[i] = remote[i] ? rxClkEff[i] : allOnesAct[i] ? mclkS
                                                                     : tclkS[i];
        assign txPosSel[i] = remote[i] ? rxPosEff[i] : allOnesAct[i] ? onesPhase_reg
                                                                     : tposS[i];
        assign txNegSel[i] = remote[i] ? rxNegEff[i] : allOnesAct[i] ? ~onesPhase_reg
                                                                     : tnegS[i];
        assign jaClk[i]    = jaTx ? txClkSel[i] : rcClkSrc[i];
        assign jaPosIn[i]  = jaTx ? txPosSel[i] : rcPosSrc[i];
        assign jaNegIn[i]  = jaTx ? txNegSel[i] : rcNegSrc[i];
        // Analog loop sees the driven line; digital loop sees raw transmit inputs
        assign rcClkSrc[i] = digLoop[i] ? tclkS[i] : analog[i] ? txClkSel[i]
                                                               : rxClkEff[i];
        assign rcPosSrc[i] = digLoop[i] ? tposS[i] : analog[i] ? lineOutPlus[i]
                                                               : rxPosEff[i];
        assign rcNegSrc[i] = digLoop[i] ? tnegS[i] : analog[i] ? lineOutMinus[i]
                                                               : rxNegEff[i];
    end

    // Attenuator modelled as a fixed-length delay line: constant latency by construction
    logic [JA_DEEP_BITS-1:0] jaPos_reg [CHN];
    logic [JA_DEEP_BITS-1:0] jaNeg_reg [CHN];
    logic [CHN-1:0]          jaClkPrev_reg;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < CHN; c++) begin
                jaPos_reg[c] <= '0;
                jaNeg_reg[c] <= '0;
            end
            jaClkPrev_reg <= '0;
        end else begin
            jaClkPrev_reg <= jaClk;
            for (int c = 0; c < CHN; c++) begin
                if (jaClk[c] && !jaClkPrev_reg[c]) begin
                    jaPos_reg[c] <= {jaPos_reg[c][JA_DEEP_BITS-2:0], jaPosIn[c]};
                    jaNeg_reg[c] <= {jaNeg_reg[c][JA_DEEP_BITS-2:0], jaNegIn[c]};
                end
            end
        end
    end

    for (genvar i = 0; i < CHN; i++) begin : g_tap
        assign jaPosOut[i] = jaDeep ? jaPos_reg[i][JA_DEEP_BITS-1]
                                    : jaPos_reg[i][JA_SHORT_BITS-1];
        assign jaNegOut[i] = jaDeep ? jaNeg_reg[i][JA_DEEP_BITS-1]
                                    : jaNeg_reg[i][JA_SHORT_BITS-1];
    end

    // Registered line and receive outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lineOutPlus      <= '0;
            lineOutMinus     <= '0;
            lineOutEn        <= '0;
            recoveredClk     <= '0;
            recoveredPosData <= '0;
            recoveredNegData <= '0;
            signalLossOut    <= '0;
            hwStatusOut      <= '0;
        end else begin
            lineOutPlus      <= jaTx ? jaPosOut : txPosSel;
            lineOutMinus     <= jaTx ? jaNegOut : txNegSel;
            // One output flop after the pin synchroniser, or after the host register
            lineOutEn        <= hwMode ? oeS : outEn_reg;
            recoveredClk     <= rcClkSrc;
            recoveredPosData <= jaTx ? rcPosSrc : jaPosOut;
            recoveredNegData <= jaTx ? rcNegSrc : jaNegOut;
            signalLossOut    <= lossSel;
            hwStatusOut      <= hwMode ? allOnesAct : '0;
        end
    end

    // Checks
    for (genvar i = 0; i < CHN; i++) begin : g_chk
        AST_REMOTE_LINE: assert property (@(posedge core_clk) disable iff (!rstn)
            remote[i] && !jaTx |=> lineOutPlus[i] == $past(rxPosEff[i]))
            else $error("remote loop line data mismatch");
        AST_REMOTE_NO_ONES: assert property (@(posedge core_clk) disable iff (!rstn)
            remote[i] |-> !allOnesAct[i])
            else $error("all-ones active in remote loop");
        AST_HOST_ONES: assert property (@(posedge core_clk) disable iff (!rstn)
            !hwMode && allOnesSel_reg[i] && !remote[i] |-> allOnesAct[i])
            else $error("host all-ones not applied");
        AST_AUTO_ONES: assert property (@(posedge core_clk) disable iff (!rstn)
            !hwMode && autoOnes_reg[i] && losS[i] && !remote[i] |-> allOnesAct[i])
            else $error("auto all-ones not applied");
        AST_HW_ONES_ENTRY: assert property (@(posedge core_clk) disable iff (!rstn)
            hwMode && tclkS[i] && hiCnt_reg[i] == 5'd16 && mclkRise ##1 tclkS[i]
            |=> hwAllOnes_reg[i])
            else $error("hardware all-ones not entered");
        AST_HW_ONES_EXIT: assert property (@(posedge core_clk) disable iff (!rstn)
            !tclkS[i] |=> hiCnt_reg[i] == 5'd0 && !hwAllOnes_reg[i])
            else $error("high count not restarted");
        AST_NO_DIGITAL_LOOPBACK_SELECT_ONES: assert property (@(posedge core_clk) disable iff (!rstn)
            allOnesAct[i] |-> !digLoop[i])
            else $error("digital loop during all-ones");
        AST_OE_DIRECT: assert property (@(posedge core_clk) disable iff (!rstn)
            !hwMode |=> lineOutEn[i] == $past(outEn_reg[i]))
            else $error("output enable lags register");
    end

    AST_ONES_TIMING: assert property (@(posedge core_clk) disable iff (!rstn)
        !mclkRise |=> $stable(onesPhase_reg))
        else $error("all-ones phase moved without reference edge");
    AST_MON_DATA: assert property (@(posedge core_clk) disable iff (!rstn)
        monActive && !monDir && !digLoop[0] && !analog[0] && jaTx
        |=> recoveredPosData[0] == $past(rposS[monSel]))
        else $error("monitored receive data not on channel 0");
    AST_MON_LOSS: assert property (@(posedge core_clk) disable iff (!rstn)
        monActive && monDir |=> signalLossOut[0] == $past(txLosS[monSel]))
        else $error("monitored loss not reported");
    AST_HW_WRITE_BLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
        hwMode && regWrEn |=> $stable(rloop_reg) && $stable(allOnesSel_reg)
        && $stable(outEn_reg))
        else $error("register written in hardware mode");
endmodule

/* framer_model.sv */
// System-side framer model: transmit clock and data for eight channels
`timescale 1ns/1ps
module framer_model (
    input  wire logic [7:0] holdHigh,
    input  wire logic [7:0] posLevel,
    input  wire logic [7:0] negLevel,
    output logic      [7:0] transmitClockIn,
    output logic      [7:0] transmitPosData,
    output logic      [7:0] transmitNegData
);
    logic linkClk = 1'b0;
    always #62.5 linkClk = ~linkClk;
    // Held high only when a test asks for it; loopback needs it running
    assign transmitClockIn = holdHigh | {8{linkClk}};
    // Data launched on the falling edge, away from the sampling edge
    initial begin
        transmitPosData = 8'h00;
        transmitNegData = 8'h00;
    end
    always @(negedge linkClk) begin
        transmitPosData <= posLevel;
        transmitNegData <= negLevel;
    end
endmodule

/* tb_top.sv */
// Self-checking bench for the E1 diagnostic control block
`timescale 1ns/1ps
module tb_top;
    import e1_diag_pkg::*;
    logic       coreClk = 1'b0, rstn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
    logic       modeSel = 1'b1, mclk = 1'b0, hwMonEn = 1'b0, hwMonDir = 1'b0, hwJaTx = 1'b0;
    logic [2:0] hwMonSel = 3'h0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00, holdHigh = 8'h00, posLevel = 8'h00, negLevel = 8'h00;
    logic [7:0] cdrClk = 8'h00, cdrPos = 8'h00, cdrNeg = 8'h00, rxLoss = 8'h00;
    logic [7:0] txLoss = 8'h00, hwOe = 8'h00, hwRl = 8'h00, hwAl = 8'h00;
    logic [7:0] regRdData, txClk, txPos, txNeg, lop, lom, loe, rclk, recovered_pos_data, recovered_neg_data, lossOut, hwSt;
    int         failures = 0, checksDone = 0;

    always #4 coreClk = ~coreClk;

    framer_model fr (.holdHigh(holdHigh), .posLevel(posLevel), .negLevel(negLevel),
        .transmitClockIn(txClk), .transmitPosData(txPos), .transmitNegData(txNeg));

    e1_diag_ctrl #(.CHN(8)) uut (.core_clk(coreClk), .rstn(rstn), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
        .modeSel(modeSel), .mclkIn(mclk), .transmitClockIn(txClk), .transmitPosData(txPos),
        .transmitNegData(txNeg), .cdrClkIn(cdrClk), .cdrPosIn(cdrPos), .cdrNegIn(cdrNeg),
        .rxSignalLossIn(rxLoss), .txSignalLossIn(txLoss), .hwOutEnPin(hwOe),
        .hwRemoteLoopPin(hwRl), .hwAnalogLoopPin(hwAl), .hwMonEnPin(hwMonEn),
        .hwMonDirPin(hwMonDir), .hwMonSelPin(hwMonSel), .hwJaTxPin(hwJaTx),
        .lineOutPlus(lop), .lineOutMinus(lom), .lineOutEn(loe), .recoveredClk(rclk),
        .recoveredPosData(recovered_pos_data), .recoveredNegData(recovered_neg_data), .signalLossOut(lossOut),
        .hwStatusOut(hwSt));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge coreClk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge coreClk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge coreClk);
        regWrEn <= 1'b0;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge coreClk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge coreClk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    task automatic mpulse(input int n);
        repeat (n) begin
            @(posedge coreClk);
            mclk <= 1'b1;
            repeat (4) @(posedge coreClk);
            mclk <= 1'b0;
            repeat (4) @(posedge coreClk);
        end
        #1;
    endtask
    // Pattern must hold while only the transmit clock runs, flip on a reference edge
    task automatic onesChk(input int ch);
        logic p;
        p = lop[ch];
        chk({7'h00, lom[ch]}, {7'h00, ~p});
        cyc(40);
        chk({7'h00, lop[ch]}, {7'h00, p});
        mpulse(1);
        chk({7'h00, lop[ch]}, {7'h00, ~p});
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole run needs about 1200 cycles; generous margin
    initial begin
        #400000;
        failures++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge coreClk);
        rstn <= 1'b1;
        cyc(1);
        chk(loe, 8'h00);
        for (int a = 0; a < 10; a++) begin
            rdChk(a[3:0], 8'h00);
        end
        rdChk(4'hf, 8'h00);
        $display("test reset done");
        wr(ADDR_OUTEN, 8'hff);
        @(posedge coreClk);
        posLevel <= 8'h0f;
        negLevel <= 8'hf0;
        cyc(24);
        chk(loe, 8'hff);
        chk(lop, 8'h0f);
        chk(lom, 8'hf0);
        rdChk(ADDR_OUTEN, 8'hff);
        $display("test transmit done");
        wr(ADDR_ALLONES, 8'h04);
        wr(ADDR_RLOOP, 8'h06);
        @(posedge coreClk);
        cdrPos <= 8'h06;
        posLevel <= 8'h00;
        negLevel <= 8'h00;
        cyc(24);
        chk(lop, 8'h06);
        @(posedge coreClk);
        cdrPos <= 8'h02;
        posLevel <= 8'h06;
        cyc(24);
        chk(lop, 8'h02);
        chk(lom, 8'h00);
        wr(ADDR_RLOOP, 8'h00);
        @(posedge coreClk);
        posLevel <= 8'h00;
        cyc(24);
        onesChk(2);
        chk(hwSt, 8'h00);
        wr(ADDR_ALLONES, 8'h00);
        $display("test remote loop and all ones done");
        wr(ADDR_AUTOONES, 8'h08);
        @(posedge coreClk);
        rxLoss <= 8'h08;
        cyc(8);
        onesChk(3);
        @(posedge coreClk);
        rxLoss <= 8'h00;
        cyc(8);
        chk({6'h00, lop[3], lom[3]}, 8'h00);
        $display("test auto ones done");
        wr(ADDR_ALLONES, 8'h10);
        // Attenuator on transmit side keeps the receive path direct
        wr(ADDR_JA, 8'h01);
        wr(ADDR_DIGITAL_LOOPBACK_SELECT, 8'h30);
        wr(ADDR_ALOOP, 8'h40);
        @(posedge coreClk);
        posLevel <= 8'h30;
        cdrPos <= 8'h40;
        cyc(24);
        chk(recovered_pos_data & 8'h70, 8'h20);
        rdChk(ADDR_JA, 8'h01);
        wr(ADDR_DIGITAL_LOOPBACK_SELECT, 8'h00);
        wr(ADDR_ALOOP, 8'h00);
        wr(ADDR_ALLONES, 8'h00);
        wr(ADDR_AUTOONES, 8'h00);
        $display("test digital loop done");
        wr(ADDR_MON, 8'h0d);
        @(posedge coreClk);
        cdrPos <= 8'h08;
        cdrNeg <= 8'h08;
        cdrClk <= 8'h08;
        rxLoss <= 8'h08;
        posLevel <= 8'h08;
        cyc(24);
        chk({5'h00, rclk[0], recovered_neg_data[0], recovered_pos_data[0]}, 8'h07);
        chk({7'h00, lossOut[0]}, 8'h01);
        wr(ADDR_JA, 8'h00);
        wr(ADDR_MON, 8'h0f);
        @(posedge coreClk);
        rxLoss <= 8'h00;
        txLoss <= 8'h08;
        cdrPos <= 8'h00;
        // Receive delay line needs 16 transmit clock edges to refill
        cyc(300);
        chk({7'h00, recovered_pos_data[0]}, 8'h01);
        chk({7'h00, lossOut[0]}, 8'h01);
        wr(ADDR_RLOOP, 8'h01);
        cyc(24);
        chk({7'h00, lop[0]}, {7'h00, lop[3]});
        chk({7'h00, lop[0]}, 8'h01);
        @(posedge coreClk);
        txLoss <= 8'h00;
        cyc(8);
        chk({7'h00, lossOut[0]}, 8'h00);
        wr(ADDR_RLOOP, 8'h00);
        wr(ADDR_OUTEN, 8'hfe);
        cyc(1);
        chk(loe, 8'hfe);
        $display("test monitor and tristate done");
        @(posedge coreClk);
        modeSel <= 1'b0;
        hwOe <= 8'hff;
        hwRl <= 8'h20;
        hwMonEn <= 1'b1;
        hwMonSel <= 3'h5;
        rxLoss <= 8'h20;
        cdrPos <= 8'h20;
        posLevel <= 8'h00;
        cyc(24);
        wr(ADDR_OUTEN, 8'h00);
        rdChk(ADDR_OUTEN, 8'h00);
        chk(loe, 8'hff);
        chk({7'h00, lop[5]}, 8'h01);
        chk({7'h00, lossOut[0]}, 8'h01);
        @(posedge coreClk);
        holdHigh <= 8'h10;
        cyc(4);
        mpulse(16);
        chk(hwSt, 8'h00);
        mpulse(1);
        cyc(3);
        chk(hwSt, 8'h10);
        onesChk(4);
        @(posedge coreClk);
        holdHigh <= 8'h00;
        cyc(40);
        chk(hwSt, 8'h00);
        @(posedge coreClk);
        holdHigh <= 8'h10;
        mpulse(10);
        @(posedge coreClk);
        holdHigh <= 8'h00;
        cyc(12);
        @(posedge coreClk);
        holdHigh <= 8'h10;
        cyc(4);
        mpulse(10);
        chk(hwSt, 8'h00);
        $display("test hardware mode done");
        finish_test();
    end
endmodule
